// ==== rtl/wwdg_pinsync.sv ====
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes the level changes slowly relative to the clock.
`timescale 1ns/1ps
`default_nettype none
module wwdg_pinsync (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic nrst_in,
	// Level
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_r;

	// Two stages, first read only by the second
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			meta_r <= 1'b0;
			q_out  <= 1'b0;
		end
		else
		begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule : wwdg_pinsync
`default_nettype wire

// ==== rtl/wwdg_pkg.sv ====
// Package for the window watchdog: register map, field layout, reset values.
// Assumes a 32-bit classic Wishbone slave port with word addressing by byte address.
package wwdg_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] WWDG_OFF_CONTROL = 4'h0;
	localparam logic [3:0] WWDG_OFF_CONFIG  = 4'h4;
	localparam logic [3:0] WWDG_OFF_STATUS  = 4'h8;
	localparam logic [3:0] WWDG_OFF_IRQMASK = 4'hc;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int WWDG_CNT_W        = 7;
	localparam int WWDG_ENABLE_BIT   = 7;
	localparam int WWDG_CNT_MSB_BIT  = 6;
	localparam int WWDG_IRQEN_BIT    = 9;
	localparam int WWDG_DIV_LSB      = 7;
	localparam int WWDG_FLAG_BIT     = 0;

	// ----------------------------------------------------------------
	// Reset values and counter landmarks
	// ----------------------------------------------------------------
	localparam logic [6:0] WWDG_CNT_RESET = 7'h7f;
	localparam logic [6:0] WWDG_WIN_RESET = 7'h7f;
	localparam logic [6:0] WWDG_CNT_WARN  = 7'h40;
	localparam logic [6:0] WWDG_CNT_TRIP  = 7'h3f;

	// ----------------------------------------------------------------
	// Prescaler: base divide 4096, doubled per select step
	// ----------------------------------------------------------------
	localparam int WWDG_PRE_BASE = 4096;
	localparam int WWDG_PRE_W    = 15;

	// Configuration fields as one carrier
	typedef struct packed {
		logic       irq_enable;
		logic [1:0] div_sel;
		logic [6:0] window_limit;
	} wwdg_cfg_t;

endpackage : wwdg_pkg

// ==== rtl/wwdg_prescaler.sv ====
// Prescaler: issues a one-cycle tick every 4096 << sel clock cycles while running.
// Assumes a single synchronous clock domain and an async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module wwdg_prescaler #(
	parameter int BASE = wwdg_pkg::WWDG_PRE_BASE
) (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	// Control
	input  wire logic       run_in,
	input  wire logic [1:0] sel_in,
	// Tick
	output logic            tick_out
);
	localparam int W = wwdg_pkg::WWDG_PRE_W;

	logic [W-1:0] cnt_r;
	logic [W-1:0] last_w;
	logic         wrap_w;

	// Terminal count from selected divide
	assign last_w   = W'((BASE << sel_in) - 1);
	assign wrap_w   = (cnt_r >= last_w);
	assign tick_out = run_in & wrap_w;

	// Divide counter, frozen while not running
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			cnt_r <= '0;
		else if (run_in)
			cnt_r <= wrap_w ? '0 : W'(cnt_r + 1'b1);
	end
endmodule : wwdg_prescaler
`default_nettype wire

// ==== rtl/wwdg_top.sv ====
// Window watchdog: 7-bit downcounter, window reload check, early warning irq.
// Assumes classic Wishbone on SYS_CLK_IN; debug halt input arrives asynchronously.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - When enabled, counter stepping 0x40 to 0x3F requests a system reset.
// - When enabled, a reload while count exceeds window limit requests reset.
// - Counter ticks at clock divided by 4096, 8192, 16384 or 32768.
// - With warning irq enabled, reaching 0x40 sets flag; irq rises only if mask bit 0 is also set.
// - Enabling while counter bit 6 is zero resets at once.
// - Enable bit 7 set by writing one, cleared only by reset.
// - Counter holds while core halted in debug with freeze set.
// - Warning flag in status bit 0, set by hardware, cleared writing zero.
module wwdg_top (
	// Clock and reset
	input  wire logic        SYS_CLK_IN,
	input  wire logic        NRST_IN,
	// Wishbone slave
	input  wire logic        WB_CYC_IN,
	input  wire logic        WB_STB_IN,
	input  wire logic        WB_WE_IN,
	input  wire logic [3:0]  WB_ADR_IN,
	input  wire logic [3:0]  WB_SEL_IN,
	input  wire logic [31:0] WB_DAT_IN,
	output logic      [31:0] WB_DAT_OUT,
	output logic             WB_ACK_OUT,
	output logic             WB_ERR_OUT,
	// Debug
	input  wire logic        CORE_HALTED_IN,
	input  wire logic        DEBUG_HALT_FREEZE_IN,
	// Outputs
	output logic             SYS_RESET_REQ_OUT,
	output logic             IRQ_OUT
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [6:0]          countdown_value_r;
	logic [6:0]          countdown_value_nxt;
	logic                window_wd_enable_r;
	wwdg_pkg::wwdg_cfg_t cfg_r;
	logic                early_warn_flag_r;
	logic                irq_mask_r;
	logic                reset_req_r;
	logic                ack_r;
	logic                err_r;
	logic [31:0]         rdata_r;
	logic                halted_sync_w;
	logic                freeze_sync_w;
	logic                run_w;
	logic                tick_w;
	logic                req_w;
	logic                full_word_w;
	logic                wr_w;
	logic                rd_w;
	logic                hit_ctrl_w;
	logic                hit_cfg_w;
	logic                hit_sts_w;
	logic                hit_msk_w;
	logic                mapped_w;
	logic                wr_ctrl_w;
	logic                en_next_w;
	logic                step_trip_w;
	logic                window_viol_w;
	logic                enable_trip_w;
	logic                warn_evt_w;
	logic                flag_clr_w;
	logic                flag_rdclr_w;
	logic [31:0]         rd_mux_w;

	// ----------------------------------------------------------------
	// Debug halt synchronisers
	// ----------------------------------------------------------------
	wwdg_pinsync u_sync_halt (
		.clk_in  (SYS_CLK_IN),
		.nrst_in (NRST_IN),
		.d_in    (CORE_HALTED_IN),
		.q_out   (halted_sync_w)
	);

	wwdg_pinsync u_sync_freeze (
		.clk_in  (SYS_CLK_IN),
		.nrst_in (NRST_IN),
		.d_in    (DEBUG_HALT_FREEZE_IN),
		.q_out   (freeze_sync_w)
	);

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	// Runs while enabled unless debug freeze holds the core
	assign run_w = window_wd_enable_r & ~(halted_sync_w & freeze_sync_w);

	wwdg_prescaler u_pre (
		.clk_in   (SYS_CLK_IN),
		.nrst_in  (NRST_IN),
		.run_in   (run_w),
		.sel_in   (cfg_r.div_sel),
		.tick_out (tick_w)
	);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// One-cycle answer; second cycle of a held request is masked by ack
	assign req_w       = WB_CYC_IN & WB_STB_IN & ~ack_r & ~err_r;
	assign full_word_w = (WB_SEL_IN == 4'hf);
	assign hit_ctrl_w  = (WB_ADR_IN == wwdg_pkg::WWDG_OFF_CONTROL);
	assign hit_cfg_w   = (WB_ADR_IN == wwdg_pkg::WWDG_OFF_CONFIG);
	assign hit_sts_w   = (WB_ADR_IN == wwdg_pkg::WWDG_OFF_STATUS);
	assign hit_msk_w   = (WB_ADR_IN == wwdg_pkg::WWDG_OFF_IRQMASK);
	// Partial-lane accesses are refused with err
	assign mapped_w    = (hit_ctrl_w | hit_cfg_w | hit_sts_w | hit_msk_w)
	                     & full_word_w;
	assign wr_w        = req_w & mapped_w & WB_WE_IN;
	assign rd_w        = req_w & mapped_w & ~WB_WE_IN;
	assign wr_ctrl_w   = wr_w & hit_ctrl_w;

	// ----------------------------------------------------------------
	// Watchdog decisions
	// ----------------------------------------------------------------
	// Enable is sticky once written as one
	assign en_next_w     = window_wd_enable_r
	                       | (wr_ctrl_w & WB_DAT_IN[wwdg_pkg::WWDG_ENABLE_BIT]);
	// Tick that moves the counter from 0x40 to 0x3F
	assign step_trip_w   = window_wd_enable_r & tick_w
	                       & (countdown_value_r == wwdg_pkg::WWDG_CNT_WARN);
	// Reload above the window limit
	assign window_viol_w = window_wd_enable_r & wr_ctrl_w
	                       & (countdown_value_r > cfg_r.window_limit);
	// Enabled with counter bit 6 clear after this write
	assign enable_trip_w = en_next_w
	                       & ~countdown_value_nxt[wwdg_pkg::WWDG_CNT_MSB_BIT];
	// Warning when a tick lands the counter on 0x40
	assign warn_evt_w    = tick_w
	                       & (countdown_value_r == 7'(wwdg_pkg::WWDG_CNT_WARN + 7'h01))
	                       & cfg_r.irq_enable;

	// Counter next value: write loads, tick decrements
	always_comb
	begin
		countdown_value_nxt = countdown_value_r;
		if (wr_ctrl_w)
			countdown_value_nxt = WB_DAT_IN[6:0];
		else if (tick_w)
			countdown_value_nxt = 7'(countdown_value_r - 7'h01);
	end

	// ----------------------------------------------------------------
	// Warning flag clears
	// ----------------------------------------------------------------
	// Writing zero clears; reading the status register also clears
	assign flag_clr_w   = wr_w & hit_sts_w & ~WB_DAT_IN[wwdg_pkg::WWDG_FLAG_BIT];
	assign flag_rdclr_w = rd_w & hit_sts_w;

	// ----------------------------------------------------------------
	// Counter and enable
	// ----------------------------------------------------------------
	// Counter and enable state
	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			countdown_value_r  <= wwdg_pkg::WWDG_CNT_RESET;
			window_wd_enable_r <= 1'b0;
		end
		else
		begin
			countdown_value_r  <= countdown_value_nxt;
			window_wd_enable_r <= en_next_w;
		end
	end

	// ----------------------------------------------------------------
	// Configuration and mask
	// ----------------------------------------------------------------
	// Configuration and interrupt mask registers
	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			cfg_r      <= '{irq_enable: 1'b0, div_sel: 2'h0,
			                window_limit: wwdg_pkg::WWDG_WIN_RESET};
			irq_mask_r <= 1'b0;
		end
		else
		begin
			if (wr_w & hit_cfg_w)
			begin
				cfg_r.irq_enable   <= WB_DAT_IN[wwdg_pkg::WWDG_IRQEN_BIT];
				cfg_r.div_sel      <= WB_DAT_IN[wwdg_pkg::WWDG_DIV_LSB +: 2];
				cfg_r.window_limit <= WB_DAT_IN[6:0];
			end
			if (wr_w & hit_msk_w)
				irq_mask_r <= WB_DAT_IN[wwdg_pkg::WWDG_FLAG_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Warning flag and reset request
	// ----------------------------------------------------------------
	// Set wins over any clear in the same cycle; reset request is sticky
	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			early_warn_flag_r <= 1'b0;
			reset_req_r       <= 1'b0;
		end
		else
		begin
			if (warn_evt_w)
				early_warn_flag_r <= 1'b1;
			else if (flag_clr_w | flag_rdclr_w)
				early_warn_flag_r <= 1'b0;
			if (step_trip_w | window_viol_w | enable_trip_w)
				reset_req_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Read data and answer
	// ----------------------------------------------------------------
	// Read mux; reserved bits read zero
	assign rd_mux_w =
		hit_ctrl_w ? {24'h000000, window_wd_enable_r, countdown_value_r} :
		hit_cfg_w  ? {22'h000000, cfg_r.irq_enable, cfg_r.div_sel, cfg_r.window_limit} :
		hit_sts_w  ? {31'h00000000, early_warn_flag_r} :
		hit_msk_w  ? {31'h00000000, irq_mask_r} :
		32'h00000000;

	// Answer one cycle after the request, err for unmapped or partial
	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			ack_r   <= 1'b0;
			err_r   <= 1'b0;
			rdata_r <= 32'h00000000;
		end
		else
		begin
			ack_r   <= req_w & mapped_w;
			err_r   <= req_w & ~mapped_w;
			rdata_r <= rd_w ? rd_mux_w : 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Port drives
	assign WB_ACK_OUT        = ack_r;
	assign WB_ERR_OUT        = err_r;
	assign WB_DAT_OUT        = rdata_r;
	assign SYS_RESET_REQ_OUT = reset_req_r;
	assign IRQ_OUT           = early_warn_flag_r & irq_mask_r;
endmodule : wwdg_top
`default_nettype wire

// ==== tb/wwdg_bench.sv ====
// Bench for the window watchdog: registers, timeout, window, enable trip, freeze.
// Assumes wwdg_top with the checker bound to it.
`timescale 1ns/1ps
`default_nettype none
module wwdg_bench;
	logic        clk, nrst, cyc, stb, we, halt, frz, ack, err, rreq, irq, ge;
	logic [3:0]  adr, sel;
	logic [31:0] wdat, rdat, rd;
	int          errors, cmp_count, n;

	wwdg_top uut (.SYS_CLK_IN(clk), .NRST_IN(nrst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .WB_ERR_OUT(err), .CORE_HALTED_IN(halt), .DEBUG_HALT_FREEZE_IN(frz),
		.SYS_RESET_REQ_OUT(rreq), .IRQ_OUT(irq));

	// Clock, 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task give_verdict;
		if (errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One classic cycle; holds until ack or err is sampled high
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		n = 0;
		{cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, s};
		do
		begin
			@(posedge clk);
			n++;
		end
		while (!(ack || err) && n < 20);
		if (n >= 20)
		begin
			errors++;
			give_verdict();
		end
		rd = rdat;
		ge = err;
		{cyc, stb, we} <= 3'h0;
		@(posedge clk);
	endtask : bus

	task wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask : wr

	task rdc(input string what, input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hf);
		check(what, rd, exp);
	endtask : rdc

	// Counts cycles until irq or reset request rises, within a bound
	task wait_sig(input logic for_rst, input int lim);
		n = 0;
		while (!(for_rst ? rreq : irq) && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= lim)
		begin
			errors++;
			give_verdict();
		end
	endtask : wait_sig

	task do_reset;
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
	endtask : do_reset

	task t_regs;
		rdc("control", 4'h0, 32'h7f);
		rdc("config", 4'h4, 32'h7f);
		rdc("status", 4'h8, 32'h0);
		bus(1'b0, 4'h1, 32'h0, 4'hf);
		check("unmapped err", {31'h0, ge}, 32'h1);
		bus(1'b1, 4'h4, 32'h0, 4'h3);
		check("partial err", {31'h0, ge}, 32'h1);
		rdc("config kept", 4'h4, 32'h7f);
	endtask : t_regs

	task t_trip;
		wr(4'h4, 32'h27f);
		wr(4'hc, 32'h1);
		wr(4'h0, 32'hc1);
		wait_sig(1'b0, 4300);
		check("warn time", {31'h0, n >= 4000 && n <= 4200}, 32'h1);
		rdc("count at warn", 4'h0, 32'hc0);
		wr(4'h8, 32'h0);
		check("irq cleared", {31'h0, irq}, 32'h0);
		rdc("status cleared", 4'h8, 32'h0);
		wait_sig(1'b1, 4300);
		check("trip time", {31'h0, n >= 4000 && n <= 4200}, 32'h1);
	endtask : t_trip

	task t_window;
		wr(4'h0, 32'hff);
		wr(4'h0, 32'h7f);
		check("no reset", {31'h0, rreq}, 32'h0);
		rdc("enable kept", 4'h0, 32'hff);
		wr(4'h4, 32'h50);
		wr(4'h0, 32'hff);
		wait_sig(1'b1, 5);
	endtask : t_window

	task t_freeze;
		{halt, frz} <= 2'h3;
		wr(4'h4, 32'h2ff);
		wr(4'hc, 32'h1);
		wr(4'h0, 32'hc1);
		repeat (9000) @(posedge clk);
		rdc("frozen count", 4'h0, 32'hc1);
		halt <= 1'b0;
		wait_sig(1'b0, 8500);
		check("slow warn", {31'h0, n >= 8000 && n <= 8400}, 32'h1);
	endtask : t_freeze

	// Slower divide selects, warning time against the selected divide
	task t_div(input logic [31:0] cfg, input int lo, input int hi);
		wr(4'h4, cfg);
		wr(4'hc, 32'h1);
		wr(4'h0, 32'hc1);
		wait_sig(1'b0, hi + 100);
		check("div warn", {31'h0, n >= lo && n <= hi}, 32'h1);
	endtask : t_div

	// Main sequence
	initial
	begin
		{nrst, cyc, stb, we, halt, frz, adr, sel, wdat} = '0;
		errors = 0;
		cmp_count = 0;
		do_reset();
		t_regs();
		t_trip();
		do_reset();
		t_window();
		do_reset();
		wr(4'h0, 32'hbf);
		wait_sig(1'b1, 5);
		do_reset();
		t_freeze();
		do_reset();
		t_div(32'h37f, 16300, 16500);
		do_reset();
		t_div(32'h3ff, 32700, 32900);
		give_verdict();
	end
endmodule : wwdg_bench
`default_nettype wire

// ==== tb/wwdg_sva.sv ====
// Checker for the window watchdog, watching only the top-level ports.
// Assumes one clock domain and an async active-low reset; bound below.
`timescale 1ns/1ps
`default_nettype none
module wwdg_sva (
	// Watched ports
	input wire logic        SYS_CLK_IN,
	input wire logic        NRST_IN,
	input wire logic        WB_CYC_IN,
	input wire logic        WB_STB_IN,
	input wire logic        WB_WE_IN,
	input wire logic [3:0]  WB_ADR_IN,
	input wire logic [3:0]  WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic        WB_ACK_OUT,
	input wire logic        WB_ERR_OUT,
	input wire logic        SYS_RESET_REQ_OUT,
	input wire logic        IRQ_OUT
);
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!NRST_IN);
	// A request is taken while nothing is answering yet
	wire logic take = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_ERR_OUT;
	wire logic ctl_wr = take && WB_WE_IN && WB_ADR_IN == 4'h0 && WB_SEL_IN == 4'hf;

	ack_timing_a: assert property (take |=> WB_ACK_OUT || WB_ERR_OUT) else $error("no answer");
	ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack too long");
	ack_cause_a: assert property ($rose(WB_ACK_OUT) |-> $past(WB_CYC_IN && WB_STB_IN))
		else $error("ack without request");
	ans_excl_a: assert property (!(WB_ACK_OUT && WB_ERR_OUT)) else $error("ack and err");
	err_sel_a: assert property (take && WB_SEL_IN != 4'hf |=> WB_ERR_OUT)
		else $error("partial access accepted");
	err_unmap_a: assert property (take && WB_ADR_IN[1:0] != 2'h0 |=> WB_ERR_OUT)
		else $error("unmapped access accepted");
	rdata_idle_a: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0) else $error("data idle");
	rst_sticky_a: assert property (SYS_RESET_REQ_OUT |=> SYS_RESET_REQ_OUT)
		else $error("reset request dropped");
	en_trip_a: assert property (ctl_wr && WB_DAT_IN[7] && !WB_DAT_IN[6] |-> ##[1:3]
		SYS_RESET_REQ_OUT) else $error("no enable trip");
	irq_clear_a: assert property (WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == 4'h8 |-> ##[1:2]
		!IRQ_OUT) else $error("irq not cleared");
endmodule : wwdg_sva
bind wwdg_top wwdg_sva chk (.SYS_CLK_IN(SYS_CLK_IN), .NRST_IN(NRST_IN), .WB_CYC_IN(WB_CYC_IN),
	.WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN),
	.WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
	.WB_ERR_OUT(WB_ERR_OUT), .SYS_RESET_REQ_OUT(SYS_RESET_REQ_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire
